// file: design/tkm_defs.svh
`ifndef TKM_DEFS_SVH
`define TKM_DEFS_SVH

// ----------------------------------------------------------------
// structure
// ----------------------------------------------------------------
`define TKM_NMOD          5
`define TKM_NKEY          4
`define TKM_NPIN          20

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define TKM_OFF_CTRL      12'h000
`define TKM_OFF_RELOAD    12'h004
`define TKM_OFF_STAT      12'h008
`define TKM_OFF_MOD_BASE  12'h020
`define TKM_MOD_STRIDE    12'h010
`define TKM_MOD_C1        12'h000
`define TKM_MOD_C0        12'h004
`define TKM_MOD_FREQ      12'h008
`define TKM_MOD_TIME      12'h00c

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define TKM_C1_TSS        7
`define TKM_C1_ROEN       5
`define TKM_C1_KOEN       4
`define TKM_C1_MASK       8'hbf
`define TKM_C0_MUX_LSB    6
`define TKM_CTRL_SLOT_OVF 6
`define TKM_CTRL_START    5
`define TKM_CTRL_CF_OVF   4
`define TKM_CTRL_T16_OVF  3
`define TKM_CTRL_SHARED   2
`define TKM_STAT_IRQ      0
`define TKM_RST_BYTE      8'h00

// ----------------------------------------------------------------
// divider taps: sys/2, sys/4, sys/8 tick when low bits all ones
// ----------------------------------------------------------------
`define TKM_DIV2_TAP      3'h1
`define TKM_DIV4_TAP      3'h3
`define TKM_DIV8_TAP      3'h7

`endif

// file: design/tkm_pkg.sv
`include "tkm_defs.svh"

package tkm_pkg;

   // ----------------------------------------------------------------
   // measurement sequencer, gray along idle -> run -> done
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      TKM_IDLE = 2'b00,
      TKM_RUN  = 2'b01,
      TKM_DONE = 2'b11
   } tkm_state_t;

   // per-module counter state
   typedef struct packed {
      logic [15:0] freq;
      logic [15:0] tcnt;
      logic [7:0]  tmr;
      logic [4:0]  slot;
      logic        done;
   } tkm_slot_t;

   // whole state of the top module
   typedef struct packed {
      tkm_state_t              st;
      logic                    start;
      logic                    shared;
      logic [1:0]              div_sel;
      logic                    slot_ovf;
      logic                    cf_ovf;
      logic                    t16_ovf;
      logic                    irq;
      logic [7:0]              reload;
      logic [4:0][7:0]         c1;
      logic [4:0][1:0]         mux;
      logic [4:0][15:0]        res_f;
      logic [4:0][15:0]        res_t;
      logic [19:0]             key_d;
      logic [4:0]              ref_d;
      logic [2:0]              div;
      logic [4:0]              ref_en;
      logic [4:0]              key_en;
      logic                    pready;
      logic                    pslverr;
      logic [31:0]             prdata;
   } tkm_top_t;

endpackage : tkm_pkg

// file: design/tkm_slot.sv
module tkm_slot
   import tkm_pkg::*;
(
   input  wire logic        clk,        // system clock
   input  wire logic        arst_n,     // async reset, low
   input  wire logic        run,        // measurement running
   input  wire logic        load,       // start rise, load timer
   input  wire logic        clr_cnt,    // clear freq/16/5-bit counters
   input  wire logic        clr_tmr,    // clear 8-bit timer
   input  wire logic [7:0]  reload,     // timer reload value
   input  wire logic        tss,        // slot clock select
   input  wire logic        ref_edge,   // reference osc edge
   input  wire logic        sys4_tick,  // system clock / 4 enable
   input  wire logic        tick16,     // 16-bit counter enable
   input  wire logic        key_edge,   // selected key osc edge
   output logic [15:0]      freq,       // frequency count
   output logic [15:0]      tcnt,       // 16-bit counter
   output logic             done,       // own slot counter overflowed
   output logic             cf_ovf,     // frequency counter wrap pulse
   output logic             t16_ovf     // 16-bit counter wrap pulse
);

   tkm_slot_t s_ff;
   tkm_slot_t nxt_s;
   logic      active;
   logic      slot_tick;

   // ----------------------------------------------------------------
   // counting
   // ----------------------------------------------------------------
   // counters halt once this module's own slot count has wrapped
   always_comb begin
      nxt_s     = s_ff;
      cf_ovf    = 1'b0;
      t16_ovf   = 1'b0;
      active    = run & ~s_ff.done;
      slot_tick = tss ? sys4_tick : ref_edge;
      if (active) begin
         if (key_edge) begin
            nxt_s.freq = s_ff.freq + 16'h0001;
            cf_ovf     = &s_ff.freq;
         end
         if (tick16) begin
            nxt_s.tcnt = s_ff.tcnt + 16'h0001;
            t16_ovf    = &s_ff.tcnt;
         end
         if (slot_tick) begin
            // reload on wrap gives (256 - reload) ticks per slot step
            if (&s_ff.tmr) begin
               nxt_s.tmr  = reload;
               nxt_s.slot = s_ff.slot + 5'h01;
               nxt_s.done = &s_ff.slot;
            end else begin
               nxt_s.tmr = s_ff.tmr + 8'h01;
            end
         end
      end
      if (load) begin
         nxt_s.tmr = reload;
      end
      if (clr_cnt) begin
         nxt_s.freq = 16'h0000;
         nxt_s.tcnt = 16'h0000;
         nxt_s.slot = 5'h00;
         nxt_s.done = 1'b0;
      end
      if (clr_tmr) begin
         nxt_s.tmr = 8'h00;
      end
   end

   // state register
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign freq = s_ff.freq;
   assign tcnt = s_ff.tcnt;
   assign done = s_ff.done;

endmodule : tkm_slot

// file: design/tkm_top.sv
// Overview of operation
// - slot clock: ref osc or sys/4
// - ref osc enabled only by its bit
// - key oscs enabled only by their bit
// - pin select bit: io or touch key
// - five identical modules, four keys each
// - each key has its own oscillator
// - count key cycles over fixed interval
// - shared mode uses module 0 slot counter
// - one start bit drives all modules
// - start clear resets counters, not timer
// - start rise switches all counters on
// - start rise enables oscillators together
// - slot overflow stops oscillators and counters
// - one interrupt on slot overflow
// - interrupt clears all module counters
// - overflow flag sets interrupt request flag
// - timer period is (256-reload)*32 ticks
// - 16-bit counter clock sys/1,2,4,8
//
// The implementer's own choices: register access over APB and the register addresses.
`include "tkm_defs.svh"

module tkm_top
   import tkm_pkg::*;
(
   input  wire logic        CLK,            // system clock, 40 MHz
   input  wire logic        ARST_N,         // async reset, low
   input  wire logic        PSEL,           // apb select
   input  wire logic        PENABLE,        // apb access phase
   input  wire logic        PWRITE,         // apb direction
   input  wire logic [11:0] PADDR,          // apb byte address
   input  wire logic [31:0] PWDATA,         // apb write data
   output logic      [31:0] PRDATA,         // apb read data
   output logic             PREADY,         // apb ready
   output logic             PSLVERR,        // apb error, unmapped
   input  wire logic [19:0] KEY_OSC,        // key sense osc outputs
   input  wire logic [4:0]  REF_OSC,        // reference osc outputs
   output logic      [4:0]  REF_OSC_EN,     // reference osc enables
   output logic      [4:0]  KEY_OSC_EN,     // key osc enables
   output logic      [19:0] PIN_TOUCH_SEL,  // pin to touch key routing
   output logic             TOUCH_IRQ       // touch key interrupt
);

   tkm_top_t    r_ff;
   tkm_top_t    nxt_r;

   logic [19:0] key_edge;
   logic [4:0]  ref_edge;
   logic [4:0]  sel_edge;
   logic        sys4_tick;
   logic        tick16;
   logic        start_rise;
   logic        start_fall;
   logic        slot_event;
   logic        clr_cnt;
   logic        run;
   logic        wr;
   logic        hit;
   logic [31:0] rdata;
   logic [4:0]  mod_done;
   logic [4:0]  mod_cf;
   logic [4:0]  mod_t16;
   logic [4:0]  koen;
   logic [4:0]  slot_tss;
   logic [4:0]  slot_ref;
   logic [4:0][15:0] mod_freq;
   logic [4:0][15:0] mod_tcnt;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // byte address of a per-module register
   function automatic logic [11:0] mod_addr(input int m, input logic [11:0] off);
      mod_addr = `TKM_OFF_MOD_BASE + 12'(m) * `TKM_MOD_STRIDE + off;
   endfunction : mod_addr

   // ----------------------------------------------------------------
   // edges, divider, shared controls
   // ----------------------------------------------------------------
   // inputs are synchronous, so one delay flop is enough for edges
   assign key_edge  = KEY_OSC & ~r_ff.key_d;
   assign ref_edge  = REF_OSC & ~r_ff.ref_d;
   assign sys4_tick = (r_ff.div[1:0] == 2'(`TKM_DIV4_TAP)) ? 1'b1 : 1'b0;
   assign run       = (r_ff.st == TKM_RUN);

   // 16-bit counter clock select
   always_comb begin
      case (r_ff.div_sel)
         2'h0:    tick16 = 1'b1;
         2'h1:    tick16 = (r_ff.div[0] == 1'(`TKM_DIV2_TAP));
         2'h2:    tick16 = (r_ff.div[1:0] == 2'(`TKM_DIV4_TAP));
         2'h3:    tick16 = (r_ff.div == `TKM_DIV8_TAP);
         default: tick16 = 1'b0;
      endcase
   end

   // key mux and per-module enable vector
   always_comb begin
      for (int m = 0; m < `TKM_NMOD; m++) begin
         sel_edge[m] = key_edge[m*`TKM_NKEY + int'(r_ff.mux[m])];
         koen[m]     = r_ff.c1[m][`TKM_C1_KOEN];
         // shared mode: every slot counter steps with module 0's, so none ends early
         slot_tss[m] = r_ff.shared ? r_ff.c1[0][`TKM_C1_TSS] : r_ff.c1[m][`TKM_C1_TSS];
         slot_ref[m] = r_ff.shared ? ref_edge[0] : ref_edge[m];
      end
   end

   // ----------------------------------------------------------------
   // five identical counter modules
   // ----------------------------------------------------------------
   generate
      for (genvar g = 0; g < `TKM_NMOD; g++) begin : g_mod
         tkm_slot u_slot (
            .clk       (CLK),
            .arst_n    (ARST_N),
            .run       (run),
            .load      (start_rise),
            .clr_cnt   (clr_cnt),
            .clr_tmr   (slot_event),
            .reload    (r_ff.reload),
            .tss       (slot_tss[g]),
            .ref_edge  (slot_ref[g]),
            .sys4_tick (sys4_tick),
            .tick16    (tick16),
            .key_edge  (sel_edge[g]),
            .freq      (mod_freq[g]),
            .tcnt      (mod_tcnt[g]),
            .done      (mod_done[g]),
            .cf_ovf    (mod_cf[g]),
            .t16_ovf   (mod_t16[g])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // apb access
   // ----------------------------------------------------------------
   assign wr = PSEL & PENABLE & PWRITE & r_ff.pready;

   // read decode; unmapped reads zero and flags an error
   always_comb begin
      rdata = 32'h0000_0000;
      hit   = 1'b1;
      case (PADDR)
         `TKM_OFF_CTRL: begin
            rdata[`TKM_CTRL_SLOT_OVF] = r_ff.slot_ovf;
            rdata[`TKM_CTRL_START]    = r_ff.start;
            rdata[`TKM_CTRL_CF_OVF]   = r_ff.cf_ovf;
            rdata[`TKM_CTRL_T16_OVF]  = r_ff.t16_ovf;
            rdata[`TKM_CTRL_SHARED]   = r_ff.shared;
            rdata[1:0]                = r_ff.div_sel;
         end
         `TKM_OFF_RELOAD: rdata[7:0] = r_ff.reload;
         `TKM_OFF_STAT:   rdata[`TKM_STAT_IRQ] = r_ff.irq;
         default:         hit = 1'b0;
      endcase
      for (int m = 0; m < `TKM_NMOD; m++) begin
         if (PADDR == mod_addr(m, `TKM_MOD_C1)) begin
            rdata[7:0] = r_ff.c1[m];
            hit        = 1'b1;
         end
         if (PADDR == mod_addr(m, `TKM_MOD_C0)) begin
            rdata[`TKM_C0_MUX_LSB +: 2] = r_ff.mux[m];
            hit                         = 1'b1;
         end
         if (PADDR == mod_addr(m, `TKM_MOD_FREQ)) begin
            rdata[15:0] = r_ff.res_f[m];
            hit         = 1'b1;
         end
         if (PADDR == mod_addr(m, `TKM_MOD_TIME)) begin
            rdata[15:0] = r_ff.res_t[m];
            hit         = 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      nxt_r       = r_ff;
      nxt_r.key_d = KEY_OSC;
      nxt_r.ref_d = REF_OSC;
      nxt_r.div   = r_ff.div + 3'h1;

      // one wait cycle, then ready with registered data
      if (PSEL && PENABLE && !r_ff.pready) begin
         nxt_r.pready  = 1'b1;
         // read data holds over writes until the next read
         if (!PWRITE) begin
            nxt_r.prdata = rdata;
         end
         nxt_r.pslverr = ~hit;
      end else begin
         nxt_r.pready  = 1'b0;
         nxt_r.pslverr = 1'b0;
      end

      // register writes; sticky flags clear when written with zero
      if (wr) begin
         case (PADDR)
            `TKM_OFF_CTRL: begin
               nxt_r.start    = PWDATA[`TKM_CTRL_START];
               nxt_r.shared   = PWDATA[`TKM_CTRL_SHARED];
               nxt_r.div_sel  = PWDATA[1:0];
               nxt_r.slot_ovf = r_ff.slot_ovf & PWDATA[`TKM_CTRL_SLOT_OVF];
               nxt_r.cf_ovf   = r_ff.cf_ovf & PWDATA[`TKM_CTRL_CF_OVF];
               nxt_r.t16_ovf  = r_ff.t16_ovf & PWDATA[`TKM_CTRL_T16_OVF];
            end
            `TKM_OFF_RELOAD: nxt_r.reload = PWDATA[7:0];
            `TKM_OFF_STAT:   nxt_r.irq    = r_ff.irq & PWDATA[`TKM_STAT_IRQ];
            default: begin
            end
         endcase
         for (int m = 0; m < `TKM_NMOD; m++) begin
            if (PADDR == mod_addr(m, `TKM_MOD_C1)) begin
               nxt_r.c1[m] = PWDATA[7:0] & `TKM_C1_MASK;
            end
            if (PADDR == mod_addr(m, `TKM_MOD_C0)) begin
               nxt_r.mux[m] = PWDATA[`TKM_C0_MUX_LSB +: 2];
            end
         end
      end

      // start edges; software is expected to configure before the rise
      start_rise = nxt_r.start & ~r_ff.start;
      start_fall = r_ff.start & ~nxt_r.start;

      // end of slot: module 0 alone, or every module with keys enabled
      if (r_ff.shared) begin
         slot_event = run & mod_done[0];
      end else begin
         slot_event = run & (&(mod_done | ~koen));
      end
      clr_cnt = start_fall | slot_event;

      // sequencer
      case (r_ff.st)
         TKM_IDLE: begin
            if (start_rise) begin
               nxt_r.st = TKM_RUN;
            end
         end
         TKM_RUN: begin
            if (start_fall) begin
               nxt_r.st = TKM_IDLE;
            end else if (slot_event) begin
               nxt_r.st = TKM_DONE;
            end
         end
         TKM_DONE: begin
            if (start_fall) begin
               nxt_r.st = TKM_IDLE;
            end
         end
         default: nxt_r.st = TKM_IDLE;
      endcase

      // counts are kept for software before the automatic clear
      if (slot_event) begin
         nxt_r.res_f    = mod_freq;
         nxt_r.res_t    = mod_tcnt;
         nxt_r.slot_ovf = 1'b1;
         nxt_r.irq      = 1'b1;
      end
      // hardware set wins over a software clear in the same cycle
      if (|mod_cf) begin
         nxt_r.cf_ovf = 1'b1;
      end
      if (|mod_t16) begin
         nxt_r.t16_ovf = 1'b1;
      end

      // oscillators run only with their bit set and a slot in progress
      // both enables follow the same next state, so all start together
      for (int m = 0; m < `TKM_NMOD; m++) begin
         nxt_r.ref_en[m] = nxt_r.c1[m][`TKM_C1_ROEN] & (nxt_r.st == TKM_RUN);
         nxt_r.key_en[m] = nxt_r.c1[m][`TKM_C1_KOEN] & (nxt_r.st == TKM_RUN);
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         r_ff <= '0;
      end else begin
         r_ff <= nxt_r;
      end
   end

   // ----------------------------------------------------------------
   // outputs, all straight from flops
   // ----------------------------------------------------------------
   assign PRDATA     = r_ff.prdata;
   assign PREADY     = r_ff.pready;
   assign PSLVERR    = r_ff.pslverr;
   assign REF_OSC_EN = r_ff.ref_en;
   assign KEY_OSC_EN = r_ff.key_en;
   assign TOUCH_IRQ  = r_ff.irq;

   // one select bit per key pin, key k of module m at bit 4m+k
   generate
      for (genvar p = 0; p < `TKM_NMOD; p++) begin : g_pin
         assign PIN_TOUCH_SEL[p*`TKM_NKEY +: `TKM_NKEY] = r_ff.c1[p][3:0];
      end
   endgenerate

endmodule : tkm_top

// file: testbench/tkm_top_chk.sv
// --------------------------------------------------------------
// port checker for the touch key control block
// --------------------------------------------------------------
module tkm_chk (
   input  wire logic        CLK,            // system clock
   input  wire logic        ARST_N,         // async reset, low
   input  wire logic        PSEL,           // apb select
   input  wire logic        PENABLE,        // apb access phase
   input  wire logic        PWRITE,         // apb direction
   input  wire logic [31:0] PRDATA,         // apb read data
   input  wire logic        PREADY,         // apb ready
   input  wire logic        PSLVERR,        // apb error
   input  wire logic [4:0]  REF_OSC_EN,     // reference osc enables
   input  wire logic [4:0]  KEY_OSC_EN,     // key osc enables
   input  wire logic [19:0] PIN_TOUCH_SEL,  // pin routing
   input  wire logic        TOUCH_IRQ       // touch key interrupt
);
   timeunit 1ns;
   timeprecision 1ps;

   logic wr_done;

   // a completed write is the only cause allowed for most output changes
   assign wr_done = PSEL && PENABLE && PWRITE && PREADY;

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!ARST_N);

   // apb steps: waiting access, then the answering cycle
   sequence s_wait;
      PSEL && PENABLE && !PREADY;
   endsequence
   sequence s_done;
      PSEL && PENABLE && PREADY;
   endsequence

   ready_timing_a: assert property (s_wait |=> s_done)
      else $error("ready not one cycle after access");
   ready_pulse_a: assert property (s_done |=> !PREADY)
      else $error("ready longer than one cycle");
   err_ready_a: assert property (PSLVERR |-> s_done)
      else $error("error without ready");
   rdata_hold_a: assert property ($changed(PRDATA) |-> $past(PSEL && PENABLE && !PWRITE))
      else $error("read data moved without a read");
   pin_sel_a: assert property ($changed(PIN_TOUCH_SEL) |-> $past(wr_done))
      else $error("pin routing moved without a write");
   osc_start_a: assert property (($past(REF_OSC_EN) == 5'h00 && REF_OSC_EN != 5'h00)
      |-> $past(wr_done)) else $error("oscillators started without a write");
   irq_stop_a: assert property ($rose(TOUCH_IRQ) |-> {REF_OSC_EN, KEY_OSC_EN} == 10'h000)
      else $error("oscillators running at interrupt");
   osc_off_a: assert property ((TOUCH_IRQ && {REF_OSC_EN, KEY_OSC_EN} == 10'h000
      && !wr_done) |=> {REF_OSC_EN, KEY_OSC_EN} == 10'h000) else $error("oscillators restarted");
   irq_clear_a: assert property ($fell(TOUCH_IRQ) |-> $past(wr_done))
      else $error("interrupt dropped without a write");
endmodule : tkm_chk

// file: testbench/tkm_pad_model.sv
// --------------------------------------------------------------
// touch pad oscillators: key i half period i%4+1, ref REF_HALF
// --------------------------------------------------------------
module tkm_pad_model #(
   parameter int REF_HALF = 4            // ref osc half period, clk cycles
) (
   input  wire logic        clk,         // system clock
   input  wire logic [4:0]  ref_en,      // reference osc enables
   input  wire logic [4:0]  key_en,      // key osc enables, per module
   output logic      [19:0] key_osc,     // key osc waveforms
   output logic      [4:0]  ref_osc      // reference osc waveforms
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [4:0][7:0]  ref_cnt_ff;
   logic [19:0][2:0] key_cnt_ff;

   // defined levels before the first edge
   initial begin
      key_osc = '0;
      ref_osc = '0;
      ref_cnt_ff = '0;
      key_cnt_ff = '0;
   end

   // stopped oscillators sit low and restart from phase zero, so modules start in step
   always @(posedge clk) begin
      for (int m = 0; m < 5; m++) begin
         ref_cnt_ff[m] <= (ref_en[m] && ref_cnt_ff[m] != 8'(REF_HALF - 1)) ?
                          ref_cnt_ff[m] + 8'h01 : 8'h00;
         ref_osc[m] <= ref_en[m] && (ref_osc[m] ^ (ref_cnt_ff[m] == 8'(REF_HALF - 1)));
      end
      for (int i = 0; i < 20; i++) begin
         key_cnt_ff[i] <= (key_en[i/4] && key_cnt_ff[i] != 3'(i % 4)) ? key_cnt_ff[i] + 3'h1 : 3'h0;
         key_osc[i] <= key_en[i/4] && (key_osc[i] ^ (key_cnt_ff[i] == 3'(i % 4)));
      end
   end
endmodule : tkm_pad_model

// file: testbench/tkm_top_test.sv
`include "tkm_defs.svh"

module tkm_top_test;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clk = 1'b0;
   logic        arst_n, psel, penable, pwrite, pready, pslverr, se, tirq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [19:0] key_osc, pin_sel;
   logic [4:0]  ref_osc, ref_en, key_en;
   int          err_total, num_checks;

   // --------------------------------------------------------------
   // clock, design and pads
   // --------------------------------------------------------------
   always #12.5 clk = ~clk;

   tkm_top tkm_top_i (.CLK(clk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .KEY_OSC(key_osc), .REF_OSC(ref_osc), .REF_OSC_EN(ref_en),
      .KEY_OSC_EN(key_en), .PIN_TOUCH_SEL(pin_sel), .TOUCH_IRQ(tirq));
   tkm_pad_model #(.REF_HALF(4)) tkm_pad_model_i (.clk(clk), .ref_en(ref_en),
      .key_en(key_en), .key_osc(key_osc), .ref_osc(ref_osc));

   // --------------------------------------------------------------
   // tasks
   // --------------------------------------------------------------
   task report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : report_and_stop

   task check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : check

   // counts from free-running oscillators are only known to a few units
   task check_rng(input logic [31:0] v, input int lo, input int hi);
      check(32'(v >= lo && v <= hi), 32'h1);
   endtask : check_rng

   task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      rd = prdata;
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 16) begin
         err_total++;
         report_and_stop();
      end
   endtask : apb

   function automatic logic [11:0] ma(input int m, input logic [11:0] off);
      return `TKM_OFF_MOD_BASE + 12'(m) * `TKM_MOD_STRIDE + off;
   endfunction : ma

   // one measurement: start, time the interrupt, check flags, then stop and clear
   task run(input logic [7:0] c, input logic [4:0] er, input logic [4:0] ek,
            input int lo, input int hi);
      int n;
      apb(`TKM_OFF_CTRL, 1'b1, {24'h0, c | 8'h20});
      @(posedge clk);
      check(32'(ref_en), 32'(er));
      check(32'(key_en), 32'(ek));
      n = 1;
      while (tirq !== 1'b1 && n < 4000) begin
         @(posedge clk);
         n++;
      end
      if (n >= 4000) begin
         err_total++;
         report_and_stop();
      end
      check_rng(n, lo, hi);
      check(32'({ref_en, key_en}), 32'h0);
      apb(`TKM_OFF_CTRL, 1'b0, 32'h0);
      check(rd, {24'h0, c | 8'h60});
      apb(`TKM_OFF_STAT, 1'b0, 32'h0);
      check(rd, 32'h1);
      apb(`TKM_OFF_CTRL, 1'b1, {24'h0, c});
      apb(`TKM_OFF_STAT, 1'b1, 32'h0);
      @(posedge clk);
      check(32'(tirq), 32'h0);
   endtask : run

   // --------------------------------------------------------------
   // main sequence
   // --------------------------------------------------------------
   initial begin
      arst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      err_total = 0;
      num_checks = 0;
      repeat (16) @(posedge clk);
      arst_n <= 1'b1;
      check(32'({ref_en, key_en, pin_sel, tirq}), 32'h0);
      apb(`TKM_OFF_CTRL, 1'b0, 32'h0);
      check(rd, 32'h0);
      apb(12'hffc, 1'b0, 32'h0);
      check(32'(se), 32'h1);
      check(rd, 32'h0);
      // five identical control registers, bit 6 unimplemented
      for (int m = 0; m < 5; m++) begin
         apb(ma(m, `TKM_MOD_C1), 1'b0, 32'h0);
         check(rd, 32'h0);
         apb(ma(m, `TKM_MOD_C1), 1'b1, 32'hff);
         apb(ma(m, `TKM_MOD_C1), 1'b0, 32'h0);
         check(rd, 32'hbf);
      end
      check(32'(pin_sel), 32'hfffff);
      apb(`TKM_OFF_RELOAD, 1'b1, 32'hff);
      for (int m = 0; m < 5; m++) apb(ma(m, `TKM_MOD_C1), 1'b1, 32'hb0);
      // every divider code and every key of every module
      for (int d = 0; d < 4; d++) begin
         for (int m = 0; m < 5; m++) apb(ma(m, `TKM_MOD_C0), 1'b1, 32'(((m + d) % 4) << 6));
         run(8'(d), 5'h1f, 5'h1f, 127, 140);
         apb(ma(0, `TKM_MOD_TIME), 1'b0, 32'h0);
         check_rng(rd, (128 >> d) - 4, (128 >> d) + 4);
         for (int m = 0; m < 5; m++) begin
            apb(ma(m, `TKM_MOD_FREQ), 1'b0, 32'h0);
            check_rng(rd, 64 / ((m + d) % 4 + 1) - 3, 64 / ((m + d) % 4 + 1) + 3);
         end
      end
      check(32'(pin_sel), 32'h0);
      // modules 1..4 on the slower reference clock: own vs shared slot counter
      for (int m = 1; m < 5; m++) apb(ma(m, `TKM_MOD_C1), 1'b1, 32'h30);
      run(8'h00, 5'h1f, 5'h1f, 248, 272);
      run(8'h04, 5'h1f, 5'h1f, 127, 140);
      // only module 0 has keys enabled; module 3 runs its reference alone
      for (int m = 1; m < 5; m++) apb(ma(m, `TKM_MOD_C1), 1'b1, (m == 3) ? 32'h20 : 32'h0);
      run(8'h00, 5'h09, 5'h01, 127, 140);
      apb(`TKM_OFF_RELOAD, 1'b1, 32'hfe);
      run(8'h00, 5'h09, 5'h01, 248, 272);
      // abort in mid-run: no interrupt, no new capture
      apb(`TKM_OFF_CTRL, 1'b1, 32'h20);
      repeat (20) @(posedge clk);
      apb(`TKM_OFF_CTRL, 1'b1, 32'h0);
      repeat (400) @(posedge clk);
      check(32'({tirq, ref_en, key_en}), 32'h0);
      apb(ma(0, `TKM_MOD_FREQ), 1'b0, 32'h0);
      check_rng(rd, 29, 35);
      report_and_stop();
   end
endmodule : tkm_top_test

bind tkm_top tkm_chk tkm_chk_i (.CLK(CLK), .ARST_N(ARST_N), .PSEL(PSEL), .PENABLE(PENABLE),
   .PWRITE(PWRITE), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
   .REF_OSC_EN(REF_OSC_EN), .KEY_OSC_EN(KEY_OSC_EN), .PIN_TOUCH_SEL(PIN_TOUCH_SEL),
   .TOUCH_IRQ(TOUCH_IRQ));
